// ===== ltic_pkg.sv
// Constants shared by the light threshold interrupt configuration block.
// Assumes the 16-bit configuration word layout with status bits in 7:5.
package ltic_pkg;

  localparam int RANGE_LSB = 12;
  localparam int CT_BIT    = 11;
  localparam int M_LSB     = 9;
  localparam int OVF_BIT   = 8;
  localparam int DONE_BIT  = 7;
  localparam int ABOVE_BIT = 6;
  localparam int BELOW_BIT = 5;
  localparam int L_BIT     = 4;
  localparam int LEVEL_BIT = 3;
  localparam int MASK_BIT  = 2;
  localparam int COUNT_LSB = 0;

  localparam int EXP_LSB = 12;

  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] RANGE_RST  = 4'hC;
  localparam logic       CT_RST     = 1'b1;
  localparam logic       LATCH_RST  = 1'b1;
  localparam logic       LEVEL_RST  = 1'b0;
  localparam logic       MASK_RST   = 1'b0;
  localparam logic [1:0] COUNT_RST  = 2'h0;
  localparam logic [3:0] EXP_ZERO   = 4'h0;

  typedef enum logic [1:0] {
    LTIC_SHUTDOWN = 2'b00,
    LTIC_SINGLE   = 2'b01,
    LTIC_CONT_A   = 2'b11,
    LTIC_CONT_B   = 2'b10
  } ltic_mode_t;

  localparam ltic_mode_t MODE_RST = LTIC_SHUTDOWN;

  function automatic logic [3:0] faultTarget(input logic [1:0] sel);
    case (sel)
      2'b00:   faultTarget = 4'h1;
      2'b01:   faultTarget = 4'h2;
      2'b10:   faultTarget = 4'h4;
      default: faultTarget = 4'h8;
    endcase
  endfunction

endpackage

// ===== ltic_fault_if.sv
// Link between the configuration logic and one consecutive-fault counter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ltic_fault_if;
  logic       sample;
  logic       hit;
  logic [1:0] countSel;
  logic       trip;
  logic       met;
  modport cnt  (input sample, input hit, input countSel, output trip, output met);
  modport user (output sample, output hit, output countSel, input trip, input met);
endinterface

// ===== ltic_fault_cnt.sv
// Consecutive-fault counter for one threshold flag.
// Assumes sample is a one-cycle pulse per finished measurement.
`timescale 1ns/1ps
module ltic_fault_cnt (
  input wire logic core_clk,
  input wire logic sys_rst,
  ltic_fault_if.cnt fi
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       trip;
    logic       met;
  } ltic_fcnt_t;

  ltic_fcnt_t stQ;
  ltic_fcnt_t stD;
  logic [3:0] target;

  assign target  = ltic_pkg::faultTarget(fi.countSel);
  assign fi.trip = stQ.trip;
  assign fi.met  = stQ.met;

  always_comb begin
    stD      = stQ;
    stD.trip = 1'b0;
    if (fi.sample) begin
      if (fi.hit) begin
        stD.cnt  = (stQ.cnt >= target) ? target : 4'(stQ.cnt + 4'h1);
        stD.trip = (stD.cnt >= target);
      end else begin
        stD.cnt = 4'h0;
      end
    end
    stD.met = (stD.cnt >= target);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_MISS_CLEARS: assert property (fi.sample && !fi.hit |=> stQ.cnt == 4'h0 && !fi.met)
    else $error("Fault count not cleared by a miss.");
  AST_ONE_FAULT: assert property (fi.sample && fi.hit && fi.countSel == 2'b00 |=> fi.trip)
    else $error("Single fault setting did not trip.");
  AST_EIGHT_FAULTS: assert property ($rose(fi.met) && fi.countSel == 2'b11 |-> stQ.cnt == 4'h8)
    else $error("Eight fault setting met early.");
  AST_TRIP_MET: assert property (fi.trip |-> fi.met)
    else $error("Trip without met level.");
endmodule

// ===== ltic_cfg.sv
// Configuration and threshold-interrupt reporting for the light sensor core.
// Assumes the serial front end gives one-cycle read and write strobes on core_clk.
`timescale 1ns/1ps
module ltic_cfg (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cfgWrStb,
  input  wire logic        cfgRdStb,
  input  wire logic [15:0] cfgWrData,
  output logic      [15:0] cfgRdData,
  input  wire logic        convDone,
  input  wire logic [15:0] convResult,
  input  wire logic        convOverflow,
  input  wire logic [15:0] lowLimit,
  input  wire logic [15:0] highLimit,
  output logic      [15:0] resultOut,
  output logic             convEnable,
  output logic             convContinuous,
  output logic             convTimeLong,
  output logic      [3:0]  range_number,
  output logic             rangeAuto,
  output logic             intPinOut,
  output logic             intPinOe
);
  typedef struct packed {
    logic [3:0]          range_number;
    logic                convTime;
    ltic_pkg::ltic_mode_t mode;
    logic                overflow;
    logic                conversion_done_status;
    logic                above_high_limit_status;
    logic                below_low_limit_status;
    logic                latchSel;
    logic                interrupt_active_level;
    logic                exponent_zeroing;
    logic [1:0]          fault_count_select;
    logic                intActive;
    logic [15:0]         rdData;
    logic [15:0]         result;
  } ltic_cfg_t;

  ltic_cfg_t   stQ;
  ltic_cfg_t   stD;
  logic [15:0] cfgWord;
  logic        hiHit;
  logic        loHit;
  logic        clearReq;

  ltic_fault_if hiIf ();
  ltic_fault_if loIf ();

  ltic_fault_cnt uHiCnt (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .fi       (hiIf)
  );

  ltic_fault_cnt uLoCnt (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .fi       (loIf)
  );

  // Mantissa scaled by its exponent, so words with different exponents compare as lux.
  function automatic logic [26:0] luxOf(input logic [15:0] v);
    luxOf = 27'({15'h0000, v[11:0]} << v[15:12]);
  endfunction

  assign hiHit = luxOf(convResult) > luxOf(highLimit);
  assign loHit = luxOf(convResult) < luxOf(lowLimit);

  assign hiIf.sample   = convDone;
  assign hiIf.hit      = hiHit;
  assign hiIf.countSel = stQ.fault_count_select;
  assign loIf.sample   = convDone;
  assign loIf.hit      = loHit;
  assign loIf.countSel = stQ.fault_count_select;

  assign cfgWord = {stQ.range_number, stQ.convTime, stQ.mode, stQ.overflow,
                    stQ.conversion_done_status, stQ.above_high_limit_status,
                    stQ.below_low_limit_status, stQ.latchSel,
                    stQ.interrupt_active_level, stQ.exponent_zeroing,
                    stQ.fault_count_select};

  // A read of the configuration word is the host's clearing action in latched mode.
  assign clearReq = cfgRdStb;

  always_comb begin
    stD = stQ;
    if (cfgRdStb) begin
      stD.rdData = cfgWord;
    end
    if (convDone) begin
      stD.overflow = convOverflow;
      if (stQ.exponent_zeroing && stQ.range_number < ltic_pkg::RANGE_AUTO) begin
        stD.result = {ltic_pkg::EXP_ZERO, convResult[11:0]};
      end else begin
        stD.result = convResult;
      end
      if (stQ.mode == ltic_pkg::LTIC_SINGLE) begin
        stD.mode = ltic_pkg::LTIC_SHUTDOWN;
      end
    end
    if (cfgWrStb) begin
      stD.range_number           = cfgWrData[ltic_pkg::RANGE_LSB +: 4];
      stD.convTime               = cfgWrData[ltic_pkg::CT_BIT];
      stD.mode                   = ltic_pkg::ltic_mode_t'(cfgWrData[ltic_pkg::M_LSB +: 2]);
      stD.latchSel               = cfgWrData[ltic_pkg::L_BIT];
      stD.interrupt_active_level = cfgWrData[ltic_pkg::LEVEL_BIT];
      stD.exponent_zeroing       = cfgWrData[ltic_pkg::MASK_BIT];
      stD.fault_count_select     = cfgWrData[ltic_pkg::COUNT_LSB +: 2];
    end
    if (cfgRdStb || (cfgWrStb && cfgWrData[ltic_pkg::M_LSB +: 2] != ltic_pkg::LTIC_SHUTDOWN)) begin
      stD.conversion_done_status = 1'b0;
    end
    if (convDone) begin
      stD.conversion_done_status = 1'b1;
    end
    if (stQ.latchSel) begin
      if (clearReq) begin
        stD.above_high_limit_status = 1'b0;
        stD.below_low_limit_status  = 1'b0;
        stD.intActive               = 1'b0;
      end
      if (hiIf.trip) begin
        stD.above_high_limit_status = 1'b1;
        stD.intActive               = 1'b1;
      end
      if (loIf.trip) begin
        stD.below_low_limit_status = 1'b1;
        stD.intActive              = 1'b1;
      end
    end else begin
      stD.above_high_limit_status = hiIf.met;
      stD.below_low_limit_status  = loIf.met;
      if (hiIf.trip) begin
        stD.intActive = 1'b1;
      end else if (loIf.trip) begin
        stD.intActive = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stQ                        <= '0;
      stQ.range_number           <= ltic_pkg::RANGE_RST;
      stQ.convTime               <= ltic_pkg::CT_RST;
      stQ.mode                   <= ltic_pkg::MODE_RST;
      stQ.latchSel               <= ltic_pkg::LATCH_RST;
      stQ.interrupt_active_level <= ltic_pkg::LEVEL_RST;
      stQ.exponent_zeroing       <= ltic_pkg::MASK_RST;
      stQ.fault_count_select     <= ltic_pkg::COUNT_RST;
    end else begin
      stQ <= stD;
    end
  end

  assign cfgRdData      = stQ.rdData;
  assign resultOut      = stQ.result;
  assign convEnable     = (stQ.mode != ltic_pkg::LTIC_SHUTDOWN);
  assign convContinuous = stQ.mode[1];
  assign convTimeLong   = stQ.convTime;
  assign range_number   = stQ.range_number;
  assign rangeAuto      = (stQ.range_number == ltic_pkg::RANGE_AUTO);
  assign intPinOut      = 1'b0;
  assign intPinOe       = stQ.intActive ^ stQ.interrupt_active_level;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_DONE_SET: assert property (convDone |=> stQ.conversion_done_status)
    else $error("Conversion-complete bit not set.");
  AST_DONE_READ_CLR: assert property (cfgRdStb && !convDone |=> !stQ.conversion_done_status)
    else $error("Read did not clear conversion-complete.");
  AST_DONE_SHUT_KEEP: assert property (cfgWrStb && !cfgRdStb && !convDone
      && cfgWrData[10:9] == 2'b00 |=> $stable(stQ.conversion_done_status))
    else $error("Shutdown write changed conversion-complete.");
  AST_LATCH_HOLD: assert property (stQ.latchSel && stQ.above_high_limit_status
      && !cfgRdStb && !cfgWrStb |=> stQ.above_high_limit_status)
    else $error("Latched high flag dropped without clearing.");
  AST_TRANSPARENT: assert property (!stQ.latchSel && !$past(cfgWrStb)
      |-> stQ.below_low_limit_status == $past(loIf.met))
    else $error("Transparent low flag does not track comparison.");
  AST_LEVEL_LOW: assert property (stQ.intActive && !stQ.interrupt_active_level
      |-> intPinOe && !intPinOut)
    else $error("Active-low interrupt not pulled low.");
  AST_LEVEL_HIGH: assert property (stQ.intActive && stQ.interrupt_active_level |-> !intPinOe)
    else $error("Active-high interrupt not released.");
  AST_EXP_MASK: assert property (convDone && stQ.exponent_zeroing
      && stQ.range_number < 4'hC && !cfgWrStb |=> resultOut[15:12] == 4'h0)
    else $error("Exponent not masked.");
  AST_HI_FLAG: assert property (stQ.latchSel && hiIf.trip |=> stQ.above_high_limit_status)
    else $error("High trip did not set flag.");

  COV_LATCHED_INT: cover property (stQ.latchSel && $rose(stQ.intActive));
  COV_TRANSP_LOW: cover property (!stQ.latchSel && $rose(stQ.below_low_limit_status));
  COV_SINGLE_DONE: cover property (stQ.mode == ltic_pkg::LTIC_SINGLE && convDone);
endmodule

// ===== ltic_host.sv
// Host side model that reaches the configuration word through read and write strobes.
// Assumes the caller enters each task just after a rising edge of core_clk.
`timescale 1ns/1ps
module ltic_host (
  input  wire logic        core_clk,
  output logic             cfgWrStb,
  output logic             cfgRdStb,
  output logic      [15:0] cfgWrData,
  input  wire logic [15:0] cfgRdData
);
  initial begin
    cfgWrStb  = 1'b0;
    cfgRdStb  = 1'b0;
    cfgWrData = 16'h0000;
  end
  task automatic wr(input logic [15:0] d);
    cfgWrStb  <= 1'b1;
    cfgWrData <= d;
    @(posedge core_clk);
    cfgWrStb  <= 1'b0;
    // Data is not held after the strobe, so a late sample sees garbage.
    cfgWrData <= ~d;
    @(posedge core_clk);
  endtask
  task automatic rd(output logic [15:0] d);
    cfgRdStb <= 1'b1;
    @(posedge core_clk);
    cfgRdStb <= 1'b0;
    @(posedge core_clk);
    d = cfgRdData;
  endtask
endmodule

// ===== ltic_cfg_bench.sv
// Self-checking bench for the configuration and threshold reporting logic.
// Assumes limits low 0100h and high 0800h, compared as mantissa shifted by exponent.
`timescale 1ns/1ps
module ltic_cfg_bench;
  logic        core_clk, sys_rst, convDone, convOverflow, cfgWrStb, cfgRdStb;
  logic [15:0] convResult, lowLimit, highLimit, cfgRdData, resultOut, cfgWrData, rd;
  logic        convEnable, convContinuous, convTimeLong, rangeAuto, intPinOut, intPinOe;
  logic [3:0]  range_number;
  int          errors, n_checks, seed, n;

  ltic_cfg dut (.core_clk, .sys_rst, .cfgWrStb, .cfgRdStb, .cfgWrData, .cfgRdData,
    .convDone, .convResult, .convOverflow, .lowLimit, .highLimit, .resultOut,
    .convEnable, .convContinuous, .convTimeLong, .range_number, .rangeAuto,
    .intPinOut, .intPinOe);
  ltic_host host (.core_clk, .cfgWrStb, .cfgRdStb, .cfgWrData, .cfgRdData);

  function automatic logic [15:0] cw(input logic [3:0] rng, input logic [1:0] md,
                                     input logic lat, lvl, msk, input logic [1:0] fsel);
    return {rng, 1'b1, md, 4'h0, lat, lvl, msk, fsel};
  endfunction
  function automatic logic [15:0] hiR();
    return {5'h03, 11'($random(seed))};
  endfunction
  function automatic logic [15:0] midR();
    return {8'h02, 8'($random(seed))};
  endfunction
  function automatic logic [15:0] loR();
    return {8'h00, 8'($random(seed))};
  endfunction

  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [15:0] r);
    convDone   <= 1'b1;
    convResult <= r;
    @(posedge core_clk);
    convDone   <= 1'b0;
    convResult <= ~r;
    // Flags settle two cycles after the pulse; three keeps pulses spaced.
    repeat (3) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    convDone = 1'b0;
    convOverflow = 1'b0;
    convResult = 16'h0000;
    lowLimit = 16'h0100;
    highLimit = 16'h0800;
    seed = 18;
    errors = 0;
    n_checks = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    host.rd(rd); chk(rd, 16'hC810);
    chk({15'h0, intPinOe}, 16'h0000); chk({15'h0, rangeAuto}, 16'h0001);
    chk({15'h0, convTimeLong}, 16'h0001);
    host.wr(16'hC9F0); host.rd(rd); chk(rd, 16'hC810);
    $display("test reset done");
    host.wr(cw(4'hC, 2'b10, 1'b0, 1'b0, 1'b0, 2'b00));
    conv(midR()); host.rd(rd); chk(rd & 16'h0080, 16'h0080);
    host.rd(rd); chk(rd & 16'h0080, 16'h0000);
    conv(midR()); host.wr(cw(4'hC, 2'b00, 1'b0, 1'b0, 1'b0, 2'b00));
    host.rd(rd); chk(rd & 16'h0080, 16'h0080);
    conv(midR()); host.wr(cw(4'hC, 2'b10, 1'b0, 1'b0, 1'b0, 2'b00));
    host.rd(rd); chk(rd & 16'h0080, 16'h0000);
    $display("test ready bit done");
    for (int k = 0; k < 4; k++) begin
      n = 1 << k;
      host.wr(cw(4'hC, 2'b10, 1'b0, 1'b0, 1'b0, k[1:0]));
      repeat (n) conv(loR());
      repeat (n - 1) conv(hiR());
      conv(midR());
      repeat (n - 1) conv(hiR());
      host.rd(rd); chk(rd & 16'h0060, 16'h0000);
      conv(hiR()); host.rd(rd); chk(rd & 16'h0060, 16'h0040);
      chk({15'h0, intPinOe}, 16'h0001);
      chk({15'h0, intPinOut}, 16'h0000);
    end
    $display("test fault count done");
    host.wr(cw(4'hC, 2'b10, 1'b0, 1'b0, 1'b0, 2'b00));
    conv(loR()); host.rd(rd); chk(rd & 16'h0060, 16'h0020);
    chk({15'h0, intPinOe}, 16'h0000);
    conv(midR()); host.rd(rd); chk(rd & 16'h0060, 16'h0000);
    host.wr(cw(4'hC, 2'b10, 1'b1, 1'b1, 1'b0, 2'b00));
    conv(hiR()); conv(midR()); chk({15'h0, intPinOe}, 16'h0000);
    host.rd(rd); chk(rd & 16'h0060, 16'h0040);
    host.rd(rd); chk(rd & 16'h0060, 16'h0000);
    chk({15'h0, intPinOe}, 16'h0001);
    $display("test latch and polarity done");
    host.wr(cw(4'h5, 2'b10, 1'b0, 1'b0, 1'b1, 2'b00));
    chk({15'h0, rangeAuto}, 16'h0000);
    chk({12'h0, range_number}, 16'h0005);
    conv(16'h3200); chk(resultOut, 16'h0200);
    host.rd(rd); chk(rd & 16'h0060, 16'h0040);
    host.wr(cw(4'hC, 2'b10, 1'b0, 1'b0, 1'b1, 2'b00));
    conv(16'h3200); chk(resultOut, 16'h3200);
    $display("test exponent mask done");
    for (int k = 0; k < 4; k++) begin
      host.wr(cw(4'hC, k[1:0], 1'b1, 1'b0, 1'b0, 2'b00));
      chk({14'h0, convContinuous, convEnable}, {14'h0, k[1], k != 0});
    end
    host.wr(cw(4'hC, 2'b01, 1'b1, 1'b0, 1'b0, 2'b00));
    conv(midR()); chk({15'h0, convEnable}, 16'h0000);
    $display("test mode decode done");
    end_of_test();
  end
endmodule
